// ==== rtl/reply_device.sv ====
// reply_device: processor-side decoder of system reply codes and data buffer
// assumes: ctrl end keeps its ordering; code held idle between replies
// How it works
// (RULE1) one-way reply link, controller to device
// (RULE2) four-bit code; zero idle, one error
// (RULE3) shared block read takes 64 bytes in
// (RULE4) unshared block read takes 64 bytes in
// (RULE5) single read ack takes 16 bytes in
// (RULE6) slave single read drives 16 bytes out
// (RULE7) slave block read drives 64 bytes out
// (RULE8) copyback ack drives 64 bytes out
// (RULE9) interrupt block takes 64 bytes, packet; code takes one 64-bit int_packet per valid cycle into a vin register
// (RULE10) writeback cancel abandons pending writeback
// (RULE11) interrupt nack drops queued interrupt packet
// (RULE12) interrupt nack sets readable status bit
// (RULE13) only interrupt packets may be nacked
// (RULE14) slave write replies are ignored
// (RULE15) write acks single and block
// (RULE16) ownership ack grants write, no data
// (RULE17) read time-out forwarded to processor
// (RULE18) read buffer four 16-byte entries
// (RULE19) outgoing writeback, store, snoop buffers
// (RULE20) writeback buffer snoopable with bypass
// (RULE21) three in, three out vector registers
// (RULE22) sample every edge, act once per code
`timescale 1ns/1ps
module reply_device (
	input wire logic mclk,
	input wire logic rst_b,
	sys_reply_if.device link,
	output sys_reply_pkg::beat_t rd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	input wire sys_reply_pkg::beat_t wb_data,
	input wire logic wb_valid,
	output logic wb_ready,
	input wire sys_reply_pkg::beat_t nc_data,
	input wire logic nc_valid,
	output logic nc_ready,
	input wire sys_reply_pkg::beat_t sn_data,
	input wire logic sn_valid,
	output logic sn_ready,
	input wire logic snoop_hit_wb,
	input wire logic [2:0] wb_snoop_index,
	output sys_reply_pkg::beat_t snoop_bypass_data,
	input wire logic [sys_reply_pkg::VEC_W-1:0] send_vec_data,
	input wire logic [1:0] send_vec_sel,
	input wire logic send_vec_we,
	output logic [3*sys_reply_pkg::VEC_W-1:0] recv_vec,
	output logic int_nack_status,
	input wire logic int_nack_clear,
	output logic error_seen,
	output logic read_timeout,
	output logic write_single_done,
	output logic write_block_done,
	output logic ownership_granted,
	output logic writeback_cancelled
);
	import sys_reply_pkg::*;
	typedef enum logic [1:0] {
		SRC_WB = 2'b00,
		SRC_NC = 2'b01,
		SRC_SN = 2'b10,
		SRC_VEC = 2'b11
	} src_e;
	typedef struct packed {
		beat_t [RD_ENTRIES-1:0] rd_mem;
		logic [1:0] rd_wr;
		logic [1:0] rd_rd;
		logic [2:0] rd_cnt;
		logic [CNT_W-1:0] in_left;
		logic [CNT_W-1:0] out_left;
		src_e out_src;
		beat_t [WB_ENTRIES-1:0] wb_mem;
		logic [2:0] wb_wr;
		logic [2:0] wb_rd;
		logic [3:0] wb_cnt;
		beat_t [NC_ENTRIES-1:0] nc_mem;
		logic [2:0] nc_wr;
		logic [2:0] nc_rd;
		logic [3:0] nc_cnt;
		beat_t [SN_ENTRIES-1:0] sn_mem;
		logic [1:0] sn_wr;
		logic [1:0] sn_rd;
		logic [2:0] sn_cnt;
		logic [VEC_REGS-1:0][VEC_W-1:0] vin;
		logic [VEC_REGS-1:0][VEC_W-1:0] vout;
		logic [1:0] vin_idx;
		logic [1:0] vout_idx;
		logic nack;
		logic [5:0] evt;
	} dev_s;
	dev_s r;
	dev_s next_r;
	beat_t sk_data;
	logic sk_valid;
	logic sk_ready;
	beat_t drive_data;
	logic drive_valid;
	logic drive_ready;
	logic take_in;
	logic take_drive;
	// outbound path through a two-entry buffer
	skid_buffer u_out (
		.mclk(mclk),
		.rst_b(rst_b),
		.in_data(drive_data),
		.in_valid(drive_valid),
		.in_ready(drive_ready),
		.out_data(link.out_data),
		.out_valid(link.out_valid),
		.out_ready(link.out_ready)
	);
	assign sk_data = link.in_data;
	assign sk_valid = link.in_valid;
	// inbound accepted only while a read window is open and room exists
	assign link.in_ready = (r.in_left != '0) && (r.rd_cnt != 3'(RD_ENTRIES)); // RULE18
	assign sk_ready = link.in_ready;
	assign take_in = sk_valid && sk_ready;
	assign wb_ready = (r.wb_cnt != 4'(WB_ENTRIES)); // RULE19
	assign nc_ready = (r.nc_cnt != 4'(NC_ENTRIES));
	assign sn_ready = (r.sn_cnt != 3'(SN_ENTRIES));
	assign rd_valid = (r.rd_cnt != '0);
	assign rd_data = r.rd_mem[r.rd_rd];
	// bypass shows the hit entry only, zero when no snoop hits
	assign snoop_bypass_data = snoop_hit_wb ? r.wb_mem[wb_snoop_index] : '0; // RULE20
	assign recv_vec = r.vin; // RULE21
	assign int_nack_status = r.nack;
	assign {error_seen, read_timeout, write_single_done, write_block_done,
		ownership_granted, writeback_cancelled} = r.evt;
	// pick the outbound source for the running drive window
	always_comb begin
		drive_data = '0;
		drive_valid = 1'b0;
		if (r.out_left != '0) begin
			case (r.out_src)
				SRC_WB: begin
					drive_data = r.wb_mem[r.wb_rd];
					drive_valid = (r.wb_cnt != '0);
				end
				SRC_NC: begin
					drive_data = r.nc_mem[r.nc_rd];
					drive_valid = (r.nc_cnt != '0);
				end
				SRC_SN: begin
					drive_data = r.sn_mem[r.sn_rd];
					drive_valid = (r.sn_cnt != '0);
				end
				default: begin
					drive_data = {r.vout[0], r.vout[1]};
					drive_valid = 1'b1;
				end
			endcase
		end
	end
	assign take_drive = drive_valid && drive_ready;
	// reply decode, buffers and vectors
	always_comb begin
		next_r = r;
		next_r.evt = '0;
		if (take_in) begin
			next_r.rd_mem[r.rd_wr] = sk_data;
			next_r.rd_wr = r.rd_wr + 2'd1;
			next_r.in_left = r.in_left - 4'd1;
		end
		if (take_drive) begin
			next_r.out_left = r.out_left - 4'd1;
			case (r.out_src)
				SRC_WB: next_r.wb_rd = r.wb_rd + 3'd1;
				SRC_NC: next_r.nc_rd = r.nc_rd + 3'd1;
				SRC_SN: next_r.sn_rd = r.sn_rd + 2'd1;
				default: next_r.out_src = r.out_src;
			endcase
		end
		if (wb_valid && wb_ready) begin
			next_r.wb_mem[r.wb_wr] = wb_data;
			next_r.wb_wr = r.wb_wr + 3'd1;
		end
		if (nc_valid && nc_ready) begin
			next_r.nc_mem[r.nc_wr] = nc_data;
			next_r.nc_wr = r.nc_wr + 3'd1;
		end
		if (sn_valid && sn_ready) begin
			next_r.sn_mem[r.sn_wr] = sn_data;
			next_r.sn_wr = r.sn_wr + 2'd1;
		end
		next_r.rd_cnt = r.rd_cnt + 3'(take_in) - 3'(rd_valid && rd_ready);
		if (rd_valid && rd_ready) begin
			next_r.rd_rd = r.rd_rd + 2'd1;
		end
		next_r.wb_cnt = r.wb_cnt + 4'(wb_valid && wb_ready)
			- 4'(take_drive && r.out_src == SRC_WB);
		next_r.nc_cnt = r.nc_cnt + 4'(nc_valid && nc_ready)
			- 4'(take_drive && r.out_src == SRC_NC);
		next_r.sn_cnt = r.sn_cnt + 3'(sn_valid && sn_ready)
			- 3'(take_drive && r.out_src == SRC_SN);
		if (send_vec_we && send_vec_sel < 2'd3) begin
			next_r.vout[send_vec_sel] = send_vec_data;
		end
		if (link.int_packet_valid) begin
			next_r.vin[r.vin_idx] = link.int_packet; // RULE9
			next_r.vin_idx = (r.vin_idx == 2'd2) ? 2'd0 : r.vin_idx + 2'd1;
		end
		if (int_nack_clear) begin
			next_r.nack = 1'b0;
		end
		// one action per non-idle code, sampled every edge
		case (link.code) // RULE22 RULE1
			RC_IDLE: next_r.evt = '0; // RULE2
			RC_ERROR: next_r.evt[5] = 1'b1; // RULE2
			RC_RD_SHARED, RC_RD_UNSHARED: next_r.in_left = 4'(BEATS_BLOCK); // RULE3 RULE4
			RC_RD_SINGLE: next_r.in_left = 4'(BEATS_SINGLE); // RULE5
			RC_SLV_RD_SINGLE: begin
				next_r.out_src = SRC_VEC; // RULE6
				next_r.out_left = 4'(BEATS_SINGLE);
			end
			RC_SLV_RD_BLOCK: begin
				next_r.out_src = SRC_NC; // RULE7
				next_r.out_left = 4'(BEATS_BLOCK);
			end
			RC_COPYBACK: begin
				next_r.out_src = SRC_SN; // RULE8
				next_r.out_left = 4'(BEATS_BLOCK);
			end
			RC_WB_CANCEL: begin
				next_r.evt[0] = 1'b1; // RULE10
				next_r.wb_cnt = '0;
				next_r.wb_rd = r.wb_wr;
			end
			RC_INT_NACK: begin
				next_r.nack = 1'b1; // RULE12 RULE13
				next_r.vout = '0; // RULE11
			end
			RC_WRITE_SINGLE: begin
				next_r.evt[3] = 1'b1; // RULE15
				next_r.out_src = SRC_NC;
				next_r.out_left = 4'(BEATS_SINGLE);
			end
			RC_WRITE_BLOCK: begin
				next_r.evt[2] = 1'b1; // RULE15
				next_r.out_src = SRC_WB;
				next_r.out_left = 4'(BEATS_BLOCK);
			end
			RC_OWNERSHIP: next_r.evt[1] = 1'b1; // RULE16
			RC_RD_TIMEOUT: next_r.evt[4] = 1'b1; // RULE17
			RC_SLV_WR_SINGLE, RC_SLV_WR_BLOCK: next_r.evt = '0; // RULE14
			default: next_r.evt = '0;
		endcase
	end
	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : reply_device

// ==== rtl/sys_reply_pkg.sv ====
// sys_reply_pkg: reply codes, buffer sizes and field layouts
// assumes: one clock shared by both ends of the reply link
package sys_reply_pkg;
	localparam int CODE_W = 4;
	localparam int BEAT_W = 128; // one 16-byte beat
	localparam int VEC_W = 64;
	localparam int VEC_REGS = 3;
	localparam int BEATS_SINGLE = 1; // 16 bytes
	localparam int BEATS_BLOCK = 4; // 64 bytes
	localparam int RD_ENTRIES = 4;
	localparam int WB_ENTRIES = 8;
	localparam int NC_ENTRIES = 8;
	localparam int SN_ENTRIES = 4;
	localparam int CNT_W = 4;
	localparam logic [CODE_W-1:0] RC_IDLE = 4'h0;
	localparam logic [CODE_W-1:0] RC_ERROR = 4'h1;
	localparam logic [CODE_W-1:0] RC_COPYBACK = 4'h2;
	localparam logic [CODE_W-1:0] RC_WB_CANCEL = 4'h3;
	localparam logic [CODE_W-1:0] RC_WRITE_SINGLE = 4'h4;
	localparam logic [CODE_W-1:0] RC_WRITE_BLOCK = 4'h5;
	localparam logic [CODE_W-1:0] RC_OWNERSHIP = 4'h6;
	localparam logic [CODE_W-1:0] RC_INT_NACK = 4'h7;
	localparam logic [CODE_W-1:0] RC_RD_UNSHARED = 4'h8;
	localparam logic [CODE_W-1:0] RC_RD_SHARED = 4'h9;
	localparam logic [CODE_W-1:0] RC_RD_SINGLE = 4'hA;
	localparam logic [CODE_W-1:0] RC_RD_TIMEOUT = 4'hB;
	localparam logic [CODE_W-1:0] RC_SLV_WR_SINGLE = 4'hC;
	localparam logic [CODE_W-1:0] RC_SLV_WR_BLOCK = 4'hD;
	localparam logic [CODE_W-1:0] RC_SLV_RD_SINGLE = 4'hE;
	localparam logic [CODE_W-1:0] RC_SLV_RD_BLOCK = 4'hF;
	typedef logic [BEAT_W-1:0] beat_t;
endpackage : sys_reply_pkg

// ==== rtl/sys_reply_if.sv ====
// sys_reply_if: reply code link plus the system data bus beats
// assumes: controller drives code and inbound beats, device drives outbound beats
`timescale 1ns/1ps
interface sys_reply_if;
	import sys_reply_pkg::*;
	logic [CODE_W-1:0] code; // one cycle per reply, idle otherwise
	beat_t in_data; // controller to device beats
	logic in_valid;
	logic in_ready;
	beat_t out_data; // device to controller beats
	logic out_valid;
	logic out_ready;
	logic [VEC_W-1:0] int_packet; // interrupt request packet on address bus
	logic int_packet_valid;
	modport device (input code, in_data, in_valid, output in_ready,
		output out_data, out_valid, input out_ready, input int_packet, int_packet_valid);
	modport ctrl (output code, in_data, in_valid, input in_ready,
		input out_data, out_valid, output out_ready, output int_packet, int_packet_valid);
endinterface : sys_reply_if

// ==== rtl/skid_buffer.sv ====
// skid_buffer: two-entry valid/ready buffer
// assumes: same clock on both sides
`timescale 1ns/1ps
module skid_buffer (
	input wire logic mclk,
	input wire logic rst_b,
	input wire sys_reply_pkg::beat_t in_data,
	input wire logic in_valid,
	output logic in_ready,
	output sys_reply_pkg::beat_t out_data,
	output logic out_valid,
	input wire logic out_ready
);
	import sys_reply_pkg::*;
	typedef struct packed {
		beat_t [1:0] mem;
		logic [1:0] cnt;
		logic rd;
		logic wr;
	} skid_s;
	skid_s r;
	skid_s next_r;
	logic push;
	logic pop;
	// honest full and empty from the count
	assign in_ready = (r.cnt != 2'd2);
	assign out_valid = (r.cnt != 2'd0);
	assign out_data = r.mem[r.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// pointer and count update
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wr] = in_data;
			next_r.wr = ~r.wr;
		end
		if (pop) begin
			next_r.rd = ~r.rd;
		end
		next_r.cnt = r.cnt + 2'(push) - 2'(pop);
	end
	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : skid_buffer

// ==== rtl/reply_ctrl.sv ====
// reply_ctrl: system controller end, issues one reply code per command
// assumes: user issues codes in legal order after device readiness
`timescale 1ns/1ps
module reply_ctrl (
	input wire logic mclk,
	input wire logic rst_b,
	sys_reply_if.ctrl link,
	input wire logic [sys_reply_pkg::CODE_W-1:0] cmd_code,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sys_reply_pkg::beat_t tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output sys_reply_pkg::beat_t rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [sys_reply_pkg::VEC_W-1:0] pkt_data,
	input wire logic pkt_valid
);
	import sys_reply_pkg::*;
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic [VEC_W-1:0] pkt;
		logic pkt_v;
	} ctrl_s;
	ctrl_s r;
	ctrl_s next_r;
	// nack kept for interrupt packets only; slave writes never sent
	assign cmd_ready = (cmd_code != RC_SLV_WR_SINGLE) && (cmd_code != RC_SLV_WR_BLOCK); // RULE13 RULE14
	assign link.code = r.code;
	assign link.int_packet = r.pkt;
	assign link.int_packet_valid = r.pkt_v;
	assign link.in_data = tx_data;
	assign link.in_valid = tx_valid;
	assign tx_ready = link.in_ready;
	assign rx_data = link.out_data;
	assign rx_valid = link.out_valid;
	assign link.out_ready = rx_ready;
	// code held for one cycle then back to idle
	always_comb begin
		next_r = r;
		next_r.code = RC_IDLE; // RULE2
		next_r.pkt_v = 1'b0;
		if (cmd_valid && cmd_ready) begin
			next_r.code = cmd_code; // RULE1
		end
		if (pkt_valid) begin
			next_r.pkt = pkt_data; // RULE9
			next_r.pkt_v = 1'b1;
		end
	end
	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : reply_ctrl

// ==== test/sys_reply_sva.sv ====
// sys_reply_sva: timing checks on the reply link between both ends
// assumes: one clock, sync active-low reset, signals of sys_reply_if
`timescale 1ns/1ps
module sys_reply_sva
	import sys_reply_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [CODE_W-1:0] code,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire beat_t out_data,
	input wire logic out_valid,
	input wire logic out_ready
);
	logic [3:0] in_left;
	logic [7:0] out_left;
	logic [7:0] out_add;
	wire in_hs = in_valid && in_ready;
	wire out_hs = out_valid && out_ready;
	// beats a drive code allows out
	always_comb begin
		case (code)
			RC_COPYBACK, RC_WRITE_BLOCK, RC_SLV_RD_BLOCK: out_add = 8'h04;
			RC_WRITE_SINGLE, RC_SLV_RD_SINGLE: out_add = 8'h01;
			default: out_add = 8'h00;
		endcase
	end
	// beats still owed in each direction
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			in_left <= 4'h0;
			out_left <= 8'h00;
		end else begin
			if (code == RC_RD_SHARED || code == RC_RD_UNSHARED)
				in_left <= 4'h4;
			else if (code == RC_RD_SINGLE)
				in_left <= 4'h1;
			else if (in_hs && in_left != 4'h0)
				in_left <= in_left - 4'h1;
			out_left <= out_left + out_add - 8'(out_hs && out_left != 8'h00);
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence rd_block_s;
		code == RC_RD_SHARED || code == RC_RD_UNSHARED;
	endsequence
	sequence four_beats_s;
		(in_hs && code == RC_IDLE) [*4];
	endsequence
	no_slave_write_a: assert property (
		code != RC_SLV_WR_SINGLE && code != RC_SLV_WR_BLOCK) else $error("slave write code sent");
	reset_idle_a: assert property ($rose(rst_b) |-> code == RC_IDLE && !out_valid)
		else $error("link busy after reset");
	in_window_a: assert property (in_hs |-> in_left != 4'h0)
		else $error("beat taken outside read window");
	out_window_a: assert property (out_hs |-> out_left != 8'h00)
		else $error("beat driven without drive code");
	out_keep_a: assert property (out_valid && !out_ready |=> out_valid)
		else $error("out beat dropped while stalled");
	out_stable_a: assert property (out_valid && !out_ready |=> $stable(out_data))
		else $error("out beat changed while stalled");
	block_four_a: assert property (rd_block_s ##1 four_beats_s |=> !in_ready)
		else $error("read window longer than four beats");
	single_one_a: assert property (code == RC_RD_SINGLE ##1 in_hs |=> !in_ready)
		else $error("single read window longer than one beat");
endmodule : sys_reply_sva

// ==== test/tb_top.sv ====
// tb_top: both link ends joined, driven and checked from their user sides
// assumes: package, interface and both ends compiled before this file
`timescale 1ns/1ps
module tb_top;
	import sys_reply_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [CODE_W-1:0] cmd_code = 4'h0;
	logic cmd_valid = 1'b0, stall = 1'b0, vec_we = 1'b0, int_nack_clear = 1'b0;
	logic rd_ready = 1'b1, rx_ready = 1'b1, rd_valid, rx_valid, cmd_ready, int_nack_status;
	logic [3:0] src_valid = 4'h0;
	wire [3:0] src_ready;
	wire [5:0] evt;
	beat_t src_data = '0;
	beat_t rd_data, rx_data;
	logic [63:0] vec_d = 64'h0;
	logic [1:0] vec_sel = 2'h0;
	logic [63:0] v [3];
	logic [63:0] pkt = 64'h0;
	logic pkt_valid = 1'b0, snoop_hit = 1'b0;
	wire [191:0] recv_vec;
	beat_t bypass;
	logic [31:0] seed = 32'h0000_c702;
	logic [31:0] st = 32'h0000_c702;
	beat_t q_in [$];
	beat_t q_out [$];
	int n_errors = 0;
	int n_tests = 0;
	logic [CODE_W-1:0] rd_code [3] = '{RC_RD_SHARED, RC_RD_UNSHARED, RC_RD_SINGLE};
	logic [CODE_W-1:0] ev_code [6] = '{RC_ERROR, RC_WB_CANCEL, RC_WRITE_SINGLE,
		RC_WRITE_BLOCK, RC_OWNERSHIP, RC_RD_TIMEOUT};
	sys_reply_if link();
	reply_ctrl u_reply_ctrl (.mclk(mclk), .rst_b(rst_b), .link(link.ctrl),
		.cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.tx_data(src_data), .tx_valid(src_valid[3]), .tx_ready(src_ready[3]),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.pkt_data(pkt), .pkt_valid(pkt_valid));
	reply_device u_reply_device (.mclk(mclk), .rst_b(rst_b), .link(link.device),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.wb_data(src_data), .wb_valid(src_valid[0]), .wb_ready(src_ready[0]),
		.nc_data(src_data), .nc_valid(src_valid[1]), .nc_ready(src_ready[1]),
		.sn_data(src_data), .sn_valid(src_valid[2]), .sn_ready(src_ready[2]),
		.snoop_hit_wb(snoop_hit), .wb_snoop_index(3'h0), .snoop_bypass_data(bypass),
		.send_vec_data(vec_d), .send_vec_sel(vec_sel), .send_vec_we(vec_we),
		.recv_vec(recv_vec),
		.int_nack_status(int_nack_status), .int_nack_clear(int_nack_clear),
		.error_seen(evt[5]), .writeback_cancelled(evt[4]), .write_single_done(evt[3]),
		.write_block_done(evt[2]), .ownership_granted(evt[1]), .read_timeout(evt[0]));
	sys_reply_sva chk (.mclk(mclk), .rst_b(rst_b), .code(link.code),
		.in_valid(link.in_valid), .in_ready(link.in_ready), .out_data(link.out_data),
		.out_valid(link.out_valid), .out_ready(link.out_ready));
	// 200 MHz clock
	always #2.5 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cmp_beat(input string what, input beat_t exp, input beat_t got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_beat
	task automatic cmp_flag(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_flag
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// one reply code through the controller end
	task automatic send(input logic [CODE_W-1:0] c);
		@(negedge mclk);
		cmd_code = c;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask : send
	// n beats into source s, valid held between beats
	task automatic push(input int s, input int n);
		int w;
		src_valid[s] = 1'b1;
		repeat (n) begin
			seed = lfsr(seed);
			src_data = {seed, ~seed, seed, ~seed};
			w = 0;
			do begin
				@(posedge mclk);
				w++;
			end while (src_ready[s] !== 1'b1 && w < 100);
			if (src_ready[s] !== 1'b1) n_errors++;
			if (s == 3) q_in.push_back(src_data);
			else q_out.push_back(src_data);
			@(negedge mclk);
		end
		src_valid[s] = 1'b0;
	endtask : push
	task automatic drain();
		int w;
		for (w = 0; w < 200 && q_in.size() + q_out.size() != 0; w++)
			@(negedge mclk);
		cmp_flag("beats left", 8'h00, 8'(q_in.size() + q_out.size()));
		repeat (4) @(negedge mclk);
	endtask : drain
	// random stalls on both drains
	always @(negedge mclk) begin
		st <= lfsr(st);
		rd_ready <= !stall || st[3];
		rx_ready <= !stall || st[7];
	end
	// every drained beat against the model queues
	always @(posedge mclk) begin
		if (rst_b && rd_valid && rd_ready)
			cmp_beat("rd_data", q_in.pop_front(), rd_data);
		if (rst_b && rx_valid && rx_ready)
			cmp_beat("rx_data", q_out.pop_front(), rx_data);
	end
	// watchdog
	initial begin
		#200_000;
		n_errors++;
		wrap_up();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		@(negedge mclk) rst_b = 1'b1;
		@(negedge mclk);
		cmp_flag("reset", 8'h00, {evt, int_nack_status, link.code != 4'h0});
		for (int i = 0; i < 2; i++) begin
			cmd_code = i ? RC_SLV_WR_BLOCK : RC_SLV_WR_SINGLE;
			cmd_valid = 1'b1;
			#1 cmp_flag("cmd_ready", 8'h00, 8'(cmd_ready));
			@(negedge mclk) cmd_valid = 1'b0;
			cmp_flag("code", 8'h00, 8'(link.code));
		end
		$display("test refuse done");
		foreach (rd_code[i]) begin
			stall = (i == 1);
			send(rd_code[i]);
			push(3, rd_code[i] == RC_RD_SINGLE ? 1 : 4);
			drain();
			$display("test read %h done", rd_code[i]);
		end
		stall = 1'b1;
		push(2, 4);
		send(RC_COPYBACK);
		drain();
		push(1, 4);
		send(RC_SLV_RD_BLOCK);
		drain();
		push(1, 1);
		send(RC_WRITE_SINGLE);
		drain();
		push(0, 4);
		snoop_hit = 1'b1;
		#1 cmp_beat("snoop_bypass_data", q_out[0], bypass);
		send(RC_WRITE_BLOCK);
		drain();
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			vec_d = {seed, ~seed};
			vec_sel = 2'(i);
			vec_we = 1'b1;
			v[i] = vec_d;
			@(negedge mclk);
		end
		vec_we = 1'b0;
		q_out.push_back({v[0], v[1]});
		send(RC_SLV_RD_SINGLE);
		drain();
		$display("test drive done");
		stall = 1'b0;
		foreach (ev_code[i]) begin
			send(ev_code[i]);
			@(negedge mclk);
			cmp_flag("event", 8'(6'h20 >> i), 8'(evt));
			@(negedge mclk);
			cmp_flag("event", 8'h00, 8'(evt));
		end
		$display("test events done");
		send(RC_INT_NACK);
		repeat (3) @(negedge mclk);
		cmp_flag("nack", 8'h01, 8'(int_nack_status));
		int_nack_clear = 1'b1;
		@(negedge mclk) int_nack_clear = 1'b0;
		cmp_flag("nack", 8'h00, 8'(int_nack_status));
		q_out.push_back('0);
		send(RC_SLV_RD_SINGLE);
		drain();
		$display("test nack done");
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			v[i] = {~seed, seed};
			pkt = v[i];
			pkt_valid = 1'b1;
			@(negedge mclk);
		end
		pkt_valid = 1'b0;
		repeat (2) @(negedge mclk);
		for (int i = 0; i < 3; i++)
			cmp_beat("recv_vec", 128'(v[i]), 128'(recv_vec[i*64 +: 64]));
		$display("test packet done");
		wrap_up();
	end
endmodule : tb_top
